// ===== design/afe_serial_params.svh
// constants of the serial register bank: offsets, fields, reset values
`ifndef AFE_SERIAL_PARAMS_SVH
`define AFE_SERIAL_PARAMS_SVH
`define ADDR_W              8
`define DATA_W              16
`define FRAME_BITS          24
`define OFS_POWER_CLAMP     8'h00
`define OFS_POLARITY_OUT    8'h01
`define OFS_SAMPLER_GAIN    8'h02
`define OFS_AMP_GAIN        8'h03
`define OFS_BLACK_LEVEL     8'h04
`define OFS_BRINGUP_FIELD         8'h05
`define OFS_TEST6           8'h06
`define OFS_TEST7           8'h07
`define OFS_TEST8           8'h08
`define OFS_TEST9           8'h09
`define OFS_TEST10          8'h0a
`define OFS_SOFT_RESET      8'h0b
`define OFS_OUT_DRIVE       8'h0c
`define OFS_VSYNC_EDGE      8'h0d
`define OFS_DEFER_SEL       8'h0e
`define RST_POWER_CLAMP     11'h504
`define RST_POLARITY_OUT    7'h00
`define RST_SAMPLER_GAIN    3'h1
`define RST_AMP_GAIN        10'h00f
`define RST_BLACK_LEVEL     11'h1ec
`define RST_BRINGUP_FIELD         4'h0
`define RST_TEST6           6'h06
`define RST_TEST8           12'hfff
`define RST_OUT_DRIVE       1'h1
`define DEFER_SAMPLER_BIT   0
`define DEFER_AMP_BIT       1
`define DEFER_LEVEL_BIT     2
`endif

// ===== design/afe_serial_pkg.sv
// types shared by the serial register bank
package afe_serial_pkg;
  typedef enum logic [1:0] {
    PWR_NORMAL   = 2'h0,
    PWR_REF_STBY = 2'h1,
    PWR_FULL_A   = 2'h2,
    PWR_FULL_B   = 2'h3
  } power_state_t;
  typedef enum logic [1:0] {
    PH_ADDR = 2'h0,
    PH_DATA = 2'h1
  } frame_phase_t;
endpackage

// ===== design/afe_serial_register_bank.sv
// serial-loaded control register bank of a ccd front end
// Notes on behaviour
// - burst sends one address, address increments
// - immediate registers update on last data bit
// - deferred gain/level applied at vsync edge
// - defer select bits 0,1,2 pick registers
// - vsync polarity bit picks triggering edge
// - power field: normal, ref standby, full
// - clamp enable resets one, enables loop
// - quick settle and gain-change quick settle bits
// - blank level select and restore bypass bits
// - sampler and output clock edge selects
// - clamp pulse and blank input levels
// - output high impedance and retime bypass
// - gray encode converter words when enabled
// - sampler gain three bits, reset one
// - amplifier gain ten bits, reset 0x0f
// - black target eleven bits, reset 0x1ec
// - soft reset bit self-clears after reset
// - output drive control resets one
// - frame is 8 address, 16 data, lsb first
// - bits sampled on rising serial clock
// - short word leaves register unchanged
// - power-on loads all defaults
`timescale 1ns/1ps
`include "afe_serial_params.svh"
module afe_serial_register_bank
  import afe_serial_pkg::*;
#(
  parameter int ADC_W = 12
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             serial_clk,
  input  wire logic             serial_load_strobe_n,
  input  wire logic             serial_in_bits,
  input  wire logic             vertical_sync,
  input  wire logic [ADC_W-1:0] adc_word,
  output logic [1:0]            power_state,
  output logic                  clamp_enable,
  output logic                  quick_settle,
  output logic                  gain_change_quick_settle,
  output logic                  blanking_level_select,
  output logic                  restore_bypass,
  output logic                  sampler_edge_select,
  output logic                  output_clock_edge_select,
  output logic                  clamp_pulse_level_select,
  output logic                  blanking_input_level_select,
  output logic                  data_out_high_z,
  output logic                  output_retime_bypass,
  output logic                  gray_enable,
  output logic [2:0]            sampler_gain,
  output logic [9:0]            amplifier_gain,
  output logic [10:0]           black_target,
  output logic [1:0]            bringup_field,
  output logic                  output_drive_control,
  output logic                  soft_reset_pulse,
  output logic [ADC_W-1:0]      data_out
);

  // binary to gray conversion
  function automatic logic [ADC_W-1:0] to_gray(input logic [ADC_W-1:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  // ---------------- link domain (serial_clk) ----------------
  logic                  ld_reset_s1_r;
  logic                  ld_reset_r;
  logic [4:0]            bit_cnt_r;
  frame_phase_t          phase_r;
  logic [`ADDR_W-1:0]    shift_addr_r;
  logic [`DATA_W-1:0]    shift_data_r;
  logic [`ADDR_W-1:0]    word_addr_r;
  logic [`ADDR_W-1:0]    cap_addr_r;
  logic [`DATA_W-1:0]    cap_data_r;
  logic                  cap_tog_r;

  // reset brought into the link clock domain
  always_ff @(posedge serial_clk) begin
    ld_reset_s1_r <= reset;
    ld_reset_r    <= ld_reset_s1_r;
  end

  // serial shifter; strobe high holds the counter clear
  always_ff @(posedge serial_clk) begin
    if (ld_reset_r || serial_load_strobe_n) begin
      bit_cnt_r <= 5'h00;
      phase_r   <= PH_ADDR;
    end else if (phase_r == PH_ADDR) begin
      shift_addr_r <= {serial_in_bits, shift_addr_r[`ADDR_W-1:1]};
      if (bit_cnt_r == 5'h07) begin
        bit_cnt_r   <= 5'h00;
        phase_r     <= PH_DATA;
        word_addr_r <= {serial_in_bits, shift_addr_r[`ADDR_W-1:1]};
      end else begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
    end else begin
      shift_data_r <= {serial_in_bits, shift_data_r[`DATA_W-1:1]};
      if (bit_cnt_r == 5'h0f) begin
        bit_cnt_r   <= 5'h00;
        word_addr_r <= word_addr_r + 8'h01;
      end else begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
    end
  end

  // complete words captured and flagged by toggle
  always_ff @(posedge serial_clk) begin
    if (ld_reset_r) begin
      cap_tog_r  <= 1'b0;
      cap_addr_r <= 8'h00;
      cap_data_r <= 16'h0000;
    end else if (!serial_load_strobe_n && phase_r == PH_DATA && bit_cnt_r == 5'h0f) begin
      cap_addr_r <= word_addr_r;
      cap_data_r <= {serial_in_bits, shift_data_r[`DATA_W-1:1]};
      cap_tog_r  <= ~cap_tog_r;
    end
  end

  // ---------------- system domain (sys_clk) ----------------
  logic [2:0]  tog_sync_r;
  logic [2:0]  vs_sync_r;
  logic        word_evt;
  logic        vs_edge;
  logic [10:0] power_clamp_r;
  logic [6:0]  polarity_out_r;
  logic [2:0]  sampler_gain_r;
  logic [9:0]  amp_gain_r;
  logic [10:0] black_level_r;
  logic [2:0]  sampler_gain_pend_r;
  logic [9:0]  amp_gain_pend_r;
  logic [10:0] black_level_pend_r;
  logic [3:0]  bringup_field_r;
  logic [5:0]  test6_r;
  logic        test7_r;
  logic [11:0] test8_r;
  logic [11:0] test9_r;
  logic        test10_r;
  logic        soft_reset_r;
  logic        out_drive_r;
  logic        vsync_edge_r;
  logic [6:0]  defer_sel_r;
  logic        bank_reset;

  // toggle and vsync synchronisers; stage 1 feeds only stage 2
  always_ff @(posedge sys_clk) begin
    tog_sync_r <= {tog_sync_r[1:0], cap_tog_r};
    vs_sync_r  <= {vs_sync_r[1:0], vertical_sync};
  end

  assign word_evt = tog_sync_r[2] ^ tog_sync_r[1];
  // active vsync edge: falling when select is 0, rising when 1
  assign vs_edge = vsync_edge_r ? (vs_sync_r[1] & ~vs_sync_r[2])
                                : (~vs_sync_r[1] & vs_sync_r[2]);
  assign bank_reset = reset || soft_reset_r;

  // immediate-type registers
  always_ff @(posedge sys_clk) begin
    if (bank_reset) begin
      power_clamp_r  <= `RST_POWER_CLAMP;
      polarity_out_r <= `RST_POLARITY_OUT;
      bringup_field_r      <= `RST_BRINGUP_FIELD;
      test6_r        <= `RST_TEST6;
      test7_r        <= 1'b0;
      test8_r        <= `RST_TEST8;
      test9_r        <= `RST_TEST8;
      test10_r       <= 1'b0;
      out_drive_r    <= `RST_OUT_DRIVE;
      vsync_edge_r   <= 1'b0;
      defer_sel_r    <= 7'h00;
    end else if (word_evt) begin
      if (cap_addr_r == `OFS_POWER_CLAMP) begin
        power_clamp_r <= cap_data_r[10:0];
      end else if (cap_addr_r == `OFS_POLARITY_OUT) begin
        polarity_out_r <= cap_data_r[6:0];
      end else if (cap_addr_r == `OFS_BRINGUP_FIELD) begin
        bringup_field_r <= cap_data_r[3:0];
      end else if (cap_addr_r == `OFS_TEST6) begin
        test6_r <= cap_data_r[5:0];
      end else if (cap_addr_r == `OFS_TEST7) begin
        test7_r <= cap_data_r[0];
      end else if (cap_addr_r == `OFS_TEST8) begin
        test8_r <= cap_data_r[11:0];
      end else if (cap_addr_r == `OFS_TEST9) begin
        test9_r <= cap_data_r[11:0];
      end else if (cap_addr_r == `OFS_TEST10) begin
        test10_r <= cap_data_r[0];
      end else if (cap_addr_r == `OFS_OUT_DRIVE) begin
        out_drive_r <= cap_data_r[0];
      end else if (cap_addr_r == `OFS_VSYNC_EDGE) begin
        vsync_edge_r <= cap_data_r[0];
      end else if (cap_addr_r == `OFS_DEFER_SEL) begin
        defer_sel_r <= cap_data_r[6:0];
      end
    end
  end

  // soft reset self-clears the cycle after it takes effect
  always_ff @(posedge sys_clk) begin
    if (reset || soft_reset_r) begin
      soft_reset_r <= 1'b0;
    end else if (word_evt && cap_addr_r == `OFS_SOFT_RESET) begin
      soft_reset_r <= cap_data_r[0];
    end
  end

  // gain and level: pending copies, applied now or at vsync
  always_ff @(posedge sys_clk) begin
    if (bank_reset) begin
      sampler_gain_pend_r <= `RST_SAMPLER_GAIN;
      amp_gain_pend_r     <= `RST_AMP_GAIN;
      black_level_pend_r  <= `RST_BLACK_LEVEL;
    end else if (word_evt) begin
      if (cap_addr_r == `OFS_SAMPLER_GAIN) begin
        sampler_gain_pend_r <= cap_data_r[2:0];
      end else if (cap_addr_r == `OFS_AMP_GAIN) begin
        amp_gain_pend_r <= cap_data_r[9:0];
      end else if (cap_addr_r == `OFS_BLACK_LEVEL) begin
        black_level_pend_r <= cap_data_r[10:0];
      end
    end
  end

  // live values; a deferred write waits for vs_edge
  always_ff @(posedge sys_clk) begin
    if (bank_reset) begin
      sampler_gain_r <= `RST_SAMPLER_GAIN;
      amp_gain_r     <= `RST_AMP_GAIN;
      black_level_r  <= `RST_BLACK_LEVEL;
    end else begin
      if (defer_sel_r[`DEFER_SAMPLER_BIT]) begin
        if (vs_edge) sampler_gain_r <= sampler_gain_pend_r;
      end else if (word_evt && cap_addr_r == `OFS_SAMPLER_GAIN) begin
        sampler_gain_r <= cap_data_r[2:0];
      end
      if (defer_sel_r[`DEFER_AMP_BIT]) begin
        if (vs_edge) amp_gain_r <= amp_gain_pend_r;
      end else if (word_evt && cap_addr_r == `OFS_AMP_GAIN) begin
        amp_gain_r <= cap_data_r[9:0];
      end
      if (defer_sel_r[`DEFER_LEVEL_BIT]) begin
        if (vs_edge) black_level_r <= black_level_pend_r;
      end else if (word_evt && cap_addr_r == `OFS_BLACK_LEVEL) begin
        black_level_r <= cap_data_r[10:0];
      end
    end
  end

  // registered outputs; data_out held at zero when drive is off
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      power_state                 <= PWR_NORMAL;
      clamp_enable                <= 1'b1;
      quick_settle                <= 1'b0;
      gain_change_quick_settle    <= 1'b0;
      blanking_level_select       <= 1'b0;
      restore_bypass              <= 1'b0;
      sampler_edge_select         <= 1'b0;
      output_clock_edge_select    <= 1'b0;
      clamp_pulse_level_select    <= 1'b0;
      blanking_input_level_select <= 1'b0;
      data_out_high_z             <= 1'b0;
      output_retime_bypass        <= 1'b0;
      gray_enable                 <= 1'b0;
      sampler_gain                <= `RST_SAMPLER_GAIN;
      amplifier_gain              <= `RST_AMP_GAIN;
      black_target                <= `RST_BLACK_LEVEL;
      bringup_field               <= 2'h0;
      output_drive_control        <= `RST_OUT_DRIVE;
      soft_reset_pulse            <= 1'b0;
      data_out                    <= '0;
    end else begin
      power_state                 <= power_clamp_r[1:0];
      clamp_enable                <= power_clamp_r[2];
      quick_settle                <= power_clamp_r[3];
      gain_change_quick_settle    <= power_clamp_r[4];
      blanking_level_select       <= power_clamp_r[5];
      restore_bypass              <= power_clamp_r[6];
      sampler_edge_select         <= polarity_out_r[0];
      output_clock_edge_select    <= polarity_out_r[1];
      clamp_pulse_level_select    <= polarity_out_r[2];
      blanking_input_level_select <= polarity_out_r[3];
      data_out_high_z             <= polarity_out_r[4];
      output_retime_bypass        <= polarity_out_r[5];
      gray_enable                 <= polarity_out_r[6];
      sampler_gain                <= sampler_gain_r;
      amplifier_gain              <= amp_gain_r;
      black_target                <= black_level_r;
      bringup_field               <= bringup_field_r[1:0];
      output_drive_control        <= out_drive_r;
      soft_reset_pulse            <= soft_reset_r;
      if (!out_drive_r) begin
        data_out <= '0;
      end else if (polarity_out_r[6]) begin
        data_out <= to_gray(adc_word);
      end else begin
        data_out <= adc_word;
      end
    end
  end

  // ---------------- assertions ----------------
  sequence s_word_seen;
    word_evt && !bank_reset;
  endsequence

  AST_DEFAULT_CLAMP: assert property (@(posedge sys_clk)
    $fell(reset) |-> clamp_enable && sampler_gain == `RST_SAMPLER_GAIN)
    else $error("clamp or gain default wrong after reset");
  AST_AMP_RESET: assert property (@(posedge sys_clk)
    $fell(reset) |-> amplifier_gain == `RST_AMP_GAIN && black_target == `RST_BLACK_LEVEL)
    else $error("gain or level default wrong");
  AST_SOFT_CLEAR: assert property (@(posedge sys_clk) disable iff (reset)
    soft_reset_r |=> !soft_reset_r ##0 out_drive_r)
    else $error("soft reset did not self clear");
  AST_IMM_POWER: assert property (@(posedge sys_clk) disable iff (reset)
    s_word_seen ##0 cap_addr_r == `OFS_POWER_CLAMP |=> power_clamp_r == $past(cap_data_r[10:0]))
    else $error("immediate register not updated");
  AST_DEFER_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
    defer_sel_r[`DEFER_AMP_BIT] && !vs_edge && !bank_reset |=> $stable(amp_gain_r))
    else $error("deferred gain changed without vsync");
  AST_DEFER_APPLY: assert property (@(posedge sys_clk) disable iff (reset)
    defer_sel_r[`DEFER_LEVEL_BIT] && vs_edge && !bank_reset
      |=> black_level_r == $past(black_level_pend_r))
    else $error("deferred level not applied");
  AST_GRAY_OUT: assert property (@(posedge sys_clk) disable iff (reset)
    polarity_out_r[6] && out_drive_r |=> data_out == to_gray($past(adc_word)))
    else $error("gray output wrong");
  AST_DRIVE_OFF: assert property (@(posedge sys_clk) disable iff (reset)
    !out_drive_r |=> data_out == '0)
    else $error("outputs not held inactive");
  AST_STROBE_CLEAR: assert property (@(posedge serial_clk) disable iff (ld_reset_r)
    serial_load_strobe_n |=> bit_cnt_r == 5'h00 && phase_r == PH_ADDR)
    else $error("counter not cleared on strobe release");
  AST_BURST_INC: assert property (@(posedge serial_clk) disable iff (ld_reset_r)
    !serial_load_strobe_n && phase_r == PH_DATA && bit_cnt_r == 5'h0f
      |=> word_addr_r == $past(word_addr_r) + 8'h01)
    else $error("burst address not advanced");

  // link-side steps of a frame, used by the checks below
  sequence s_addr_last;
    !serial_load_strobe_n && phase_r == PH_ADDR && bit_cnt_r == 5'h07;
  endsequence

  sequence s_data_last;
    !serial_load_strobe_n && phase_r == PH_DATA && bit_cnt_r == 5'h0f;
  endsequence

  // eighth address bit opens the data phase with a fresh count
  AST_ADDR_DONE: assert property (@(posedge serial_clk) disable iff (ld_reset_r)
    s_addr_last |=> phase_r == PH_DATA && bit_cnt_r == 5'h00)
    else $error("data phase not entered after address");
  // the sixteenth bit flags the word and lands as its top bit
  AST_WORD_FLAG: assert property (@(posedge serial_clk) disable iff (ld_reset_r)
    s_data_last |=> cap_tog_r != $past(cap_tog_r) && cap_data_r[15] == $past(serial_in_bits))
    else $error("complete word not flagged");
  // no word is flagged while the strobe is released, so cut words vanish
  AST_SHORT_DROP: assert property (@(posedge serial_clk) disable iff (ld_reset_r)
    serial_load_strobe_n |=> $stable(cap_tog_r))
    else $error("word flagged outside a frame");
  // soft reset puts the bank back to its defaults one cycle later
  AST_SOFT_DEFAULTS: assert property (@(posedge sys_clk) disable iff (reset)
    soft_reset_r |=> power_clamp_r == `RST_POWER_CLAMP && amp_gain_r == `RST_AMP_GAIN)
    else $error("soft reset left a register off its default");
  // an undeferred sampler gain write takes effect on its word event
  AST_IMM_SAMPLER: assert property (@(posedge sys_clk) disable iff (reset)
    s_word_seen ##0 cap_addr_r == `OFS_SAMPLER_GAIN && !defer_sel_r[`DEFER_SAMPLER_BIT]
      |=> sampler_gain_r == $past(cap_data_r[2:0]))
    else $error("undeferred sampler gain not updated");
  // a deferred sampler gain holds until the chosen vsync edge
  AST_DEFER_SAMPLER: assert property (@(posedge sys_clk) disable iff (reset)
    defer_sel_r[`DEFER_SAMPLER_BIT] && !vs_edge && !bank_reset |=> $stable(sampler_gain_r))
    else $error("deferred sampler gain changed without vsync");
  // with gray off and drive on the word passes one cycle late
  AST_PLAIN_OUT: assert property (@(posedge sys_clk) disable iff (reset)
    out_drive_r && !polarity_out_r[6] |=> data_out == $past(adc_word))
    else $error("plain output word wrong");

endmodule

// ===== sim/afe_serial_host_model.sv
// host side model that drives the three-wire serial write link
`timescale 1ns/1ps
module afe_serial_host_model (
  output logic serial_clk,
  output logic serial_load_strobe_n,
  output logic serial_in_bits
);
  localparam realtime HALF = 62.5;

  // link idles with clock low and strobe released
  initial begin
    serial_clk           = 1'b0;
    serial_load_strobe_n = 1'b1;
    serial_in_bits       = 1'b0;
  end

  // data changes while the clock is low and is taken on the rise
  task automatic put_bit(input logic b);
    serial_in_bits = b;
    #HALF serial_clk = 1'b1;
    #HALF serial_clk = 1'b0;
  endtask

  // ticks with strobe high; data shows the inverse so no stale bit looks valid
  task automatic idle_ticks(input int n);
    serial_in_bits = ~serial_in_bits;
    repeat (n) begin
      #HALF serial_clk = 1'b1;
      #HALF serial_clk = 1'b0;
    end
  endtask

  // one frame: address once, then words; the last may be cut short on purpose
  task automatic send(input logic [7:0] a, input logic [15:0] words [$], input int last_bits);
    #HALF serial_load_strobe_n = 1'b0;
    for (int i = 0; i < 8; i++) put_bit(a[i]);
    foreach (words[w]) begin
      for (int i = 0; i < ((w == words.size() - 1) ? last_bits : 16); i++) begin
        put_bit(words[w][i]);
      end
    end
    serial_load_strobe_n = 1'b1;
    idle_ticks(2);  // clock stands still once these are done
  endtask
endmodule

// ===== sim/afe_serial_register_bank_bench.sv
// self-checking bench of the serial register bank
`timescale 1ns/1ps
`include "afe_serial_params.svh"
module afe_serial_register_bank_bench
  import afe_serial_pkg::*;
;
  logic        sys_clk, reset, vertical_sync;
  logic [11:0] adc_word, data_out;
  logic        serial_clk, serial_load_strobe_n, serial_in_bits;
  logic [1:0]  power_state, bringup_field;
  logic        clamp_enable, quick_settle, gain_change_quick_settle;
  logic        blanking_level_select, restore_bypass, sampler_edge_select;
  logic        output_clock_edge_select, clamp_pulse_level_select;
  logic        blanking_input_level_select, data_out_high_z, output_retime_bypass;
  logic        gray_enable, output_drive_control, soft_reset_pulse;
  logic [2:0]  sampler_gain;
  logic [9:0]  amplifier_gain;
  logic [10:0] black_target;
  int          err_total = 0;
  int          checked = 0;
  int          pulses = 0;
  wire  [6:0]  cfg0 = {restore_bypass, blanking_level_select, gain_change_quick_settle,
                       quick_settle, clamp_enable, power_state};
  wire  [6:0]  cfg1 = {gray_enable, output_retime_bypass, data_out_high_z,
                       blanking_input_level_select, clamp_pulse_level_select,
                       output_clock_edge_select, sampler_edge_select};

  afe_serial_register_bank #(.ADC_W(12)) i_dut (
    .sys_clk(sys_clk), .reset(reset), .serial_clk(serial_clk),
    .serial_load_strobe_n(serial_load_strobe_n), .serial_in_bits(serial_in_bits),
    .vertical_sync(vertical_sync), .adc_word(adc_word), .power_state(power_state),
    .clamp_enable(clamp_enable), .quick_settle(quick_settle),
    .gain_change_quick_settle(gain_change_quick_settle),
    .blanking_level_select(blanking_level_select), .restore_bypass(restore_bypass),
    .sampler_edge_select(sampler_edge_select),
    .output_clock_edge_select(output_clock_edge_select),
    .clamp_pulse_level_select(clamp_pulse_level_select),
    .blanking_input_level_select(blanking_input_level_select),
    .data_out_high_z(data_out_high_z), .output_retime_bypass(output_retime_bypass),
    .gray_enable(gray_enable), .sampler_gain(sampler_gain),
    .amplifier_gain(amplifier_gain), .black_target(black_target),
    .bringup_field(bringup_field), .output_drive_control(output_drive_control),
    .soft_reset_pulse(soft_reset_pulse), .data_out(data_out));

  afe_serial_host_model i_host (
    .serial_clk(serial_clk), .serial_load_strobe_n(serial_load_strobe_n),
    .serial_in_bits(serial_in_bits));

  // system clock, 50 ns period
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // the self-clearing pulse lasts one cycle, so count it as it passes
  always @(posedge sys_clk) begin
    if (soft_reset_pulse === 1'b1) pulses <= pulses + 1;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    if (err_total == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // register effect lands within six cycles of the last bit; ten leaves margin
  task automatic settle();
    repeat (10) @(posedge sys_clk);
    #1;
  endtask

  task automatic burst(input logic [7:0] a, input logic [15:0] q [$], input int last);
    i_host.send(a, q, last);
    settle();
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    burst(a, '{d}, 16);
  endtask

  // vsync is taken through a synchroniser, so give it time to act
  task automatic vs(input logic v);
    @(posedge sys_clk);
    #1 vertical_sync = v;
    settle();
  endtask

  task automatic t_defaults();
    chk("power_clamp", 16'h0004, {9'h0, cfg0});
    chk("polarity", 16'h0000, {9'h0, cfg1});
    chk("sampler_gain", 16'h0001, {13'h0, sampler_gain});
    chk("amplifier_gain", 16'h000f, {6'h0, amplifier_gain});
    chk("black_target", 16'h01ec, {5'h0, black_target});
    chk("drive", 16'h0001, {15'h0, output_drive_control});
    chk("bringup", 16'h0000, {14'h0, bringup_field});
  endtask

  // every power code, with bits 2..6 toggled both ways across the loop
  task automatic t_power();
    power_state_t pw [4] = '{PWR_NORMAL, PWR_REF_STBY, PWR_FULL_A, PWR_FULL_B};
    logic [4:0] pat [4] = '{5'h15, 5'h0a, 5'h00, 5'h1f};
    for (int k = 0; k < 4; k++) begin
      wr(`OFS_POWER_CLAMP, {5'h00, 2'h2, 2'h2, pat[k], pw[k]});
      chk("power_clamp", {9'h0, pat[k], pw[k]}, {9'h0, cfg0});
    end
  endtask

  task automatic t_polarity();
    logic [6:0] v [3] = '{7'h55, 7'h2a, 7'h00};
    for (int k = 0; k < 3; k++) begin
      wr(`OFS_POLARITY_OUT, {9'h0, v[k]});
      chk("polarity", {9'h0, v[k]}, {9'h0, cfg1});
    end
  endtask

  // one address, four words reaching the bring-up field
  task automatic t_burst();
    burst(`OFS_SAMPLER_GAIN, '{16'h0003, 16'h03ff, 16'h07ff, 16'h0003}, 16);
    chk("sampler_gain", 16'h0003, {13'h0, sampler_gain});
    chk("amplifier_gain", 16'h03ff, {6'h0, amplifier_gain});
    chk("black_target", 16'h07ff, {5'h0, black_target});
    chk("bringup", 16'h0003, {14'h0, bringup_field});
  endtask

  // second word cut at fifteen bits must be dropped; next frame starts afresh
  task automatic t_short();
    burst(`OFS_SAMPLER_GAIN, '{16'h0002, 16'h0000}, 15);
    chk("sampler_gain", 16'h0002, {13'h0, sampler_gain});
    chk("amplifier_gain", 16'h03ff, {6'h0, amplifier_gain});
    wr(`OFS_AMP_GAIN, 16'h0155);
    chk("amplifier_gain", 16'h0155, {6'h0, amplifier_gain});
  endtask

  task automatic t_defer();
    wr(`OFS_DEFER_SEL, 16'h0007);
    burst(`OFS_SAMPLER_GAIN, '{16'h0001, 16'h00aa, 16'h0100}, 16);
    chk("sampler_gain", 16'h0002, {13'h0, sampler_gain});
    chk("amplifier_gain", 16'h0155, {6'h0, amplifier_gain});
    chk("black_target", 16'h07ff, {5'h0, black_target});
    vs(1'b0);
    chk("sampler_gain", 16'h0001, {13'h0, sampler_gain});
    chk("amplifier_gain", 16'h00aa, {6'h0, amplifier_gain});
    chk("black_target", 16'h0100, {5'h0, black_target});
    wr(`OFS_VSYNC_EDGE, 16'h0001);
    wr(`OFS_SAMPLER_GAIN, 16'h0003);
    vs(1'b1);
    chk("sampler_gain", 16'h0003, {13'h0, sampler_gain});
    wr(`OFS_SAMPLER_GAIN, 16'h0000);
    vs(1'b0);
    chk("sampler_gain", 16'h0003, {13'h0, sampler_gain});
    wr(`OFS_DEFER_SEL, 16'h0001);
    wr(`OFS_AMP_GAIN, 16'h00f0);
    chk("amplifier_gain", 16'h00f0, {6'h0, amplifier_gain});
  endtask

  task automatic t_soft();
    int p0 = pulses;
    wr(`OFS_SOFT_RESET, 16'h0001);
    chk("soft_pulses", 16'h0001, 16'(pulses - p0));
    t_defaults();
  endtask

  task automatic t_data();
    logic [11:0] w = 12'h5a3;
    @(posedge sys_clk);
    #1 adc_word = w;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("data_plain", {4'h0, w}, {4'h0, data_out});
    wr(`OFS_POLARITY_OUT, 16'h0040);
    chk("data_gray", {4'h0, w ^ (w >> 1)}, {4'h0, data_out});
    wr(`OFS_OUT_DRIVE, 16'h0000);
    chk("data_off", 16'h0000, {4'h0, data_out});
    chk("drive", 16'h0000, {15'h0, output_drive_control});
  endtask

  // main sequence; link clock ticks in reset so its synchroniser sees it
  initial begin
    reset         = 1'b1;
    vertical_sync = 1'b1;
    adc_word      = 12'h000;
    fork
      repeat (6) @(posedge sys_clk);
      i_host.idle_ticks(2);
    join
    #1 reset = 1'b0;
    i_host.idle_ticks(3);
    settle();
    t_defaults();
    t_power();
    t_polarity();
    t_burst();
    t_short();
    t_defer();
    t_soft();
    t_data();
    test_done();
  end

  // about twenty frames of four microseconds each fit well inside this
  initial begin
    #1000000;
    err_total++;
    test_done();
  end
endmodule
